/* File: design/acs_device.sv */
//
// Overview of operation
// - acquisition runs from conversion end to start edge
// - host allows 100 ns acquisition before start
// - results are 10-bit straight binary codes
// - channel zero selects temperature, reset default
// - temperature code equals (degrees plus 103) times four
// - minus 55 and plus 125 codes match mapping
// - mode chosen by start level at conversion end
// - start high at end keeps device powered
// - host waits 100 ns after serial access
// - start low at end powers down device
// - start rising edge powers device back up
// - busy falling edge marks conversion complete
// - start edge holds sample, busy 9 or 27 us
// - control byte with zero top bits loads channel
`timescale 1ns/1ps
`default_nettype none
module acs_device (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // link to host
  acs_if.device     link,
  // analog front end model inputs
  input  wire logic [acs_pkg::RES_W-1:0] ext_code,
  input  wire logic [acs_pkg::RES_W-1:0] temp_code,
  // status towards the user side
  output logic                         acquiring,
  output logic                         sample_held,
  output logic [acs_pkg::CHAN_W-1:0]   channel
);

  // sequencer state
  acs_pkg::acs_dev_state_t    state_reg, state_next;
  logic [acs_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic                       busy_reg, busy_next;
  logic                       pd_reg, pd_next;
  logic                       acq_reg, acq_next;
  logic                       held_reg, held_next;
  // frozen sample and published result
  logic [acs_pkg::RES_W-1:0]  sample_reg, sample_next;
  logic [acs_pkg::RES_W-1:0]  result_reg, result_next;
  // channel address register
  logic [acs_pkg::CHAN_W-1:0] chan_reg, chan_next;
  logic                       addr_write;
  // start pin history and the events drawn from it
  logic                       start_n_reg, start_n_next;
  logic                       fall_edge;
  logic                       rise_edge;
  logic                       conv_begin;
  logic                       conv_end;

  // true when a channel code points at the temperature sensor
  function automatic logic is_temp_chan(input logic [acs_pkg::CHAN_W-1:0] ch);
    return ch == acs_pkg::CHAN_TEMP;
  endfunction

  // conversion length in clocks less one; the zero count is the edge that drops busy
  function automatic logic [acs_pkg::CNT_W-1:0] conv_load(input logic [acs_pkg::CHAN_W-1:0] ch);
    return is_temp_chan(ch) ? acs_pkg::CNT_W'(acs_pkg::CONV_TEMP_CYC - 1) :
                              acs_pkg::CNT_W'(acs_pkg::CONV_EXT_CYC - 1);
  endfunction

  // start pin copy; it resets to the idle high level so no false fall follows reset
  always_comb begin
    start_n_next = link.conversion_start_n;
  end

  // start pin register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_n_reg <= 1'b1;
    end else begin
      start_n_reg <= start_n_next;
    end
  end

  // start pin edges against its registered copy
  assign fall_edge = start_n_reg & ~link.conversion_start_n;
  assign rise_edge = ~start_n_reg & link.conversion_start_n;

  // a fall only starts a conversion while tracking; falls during busy or power-down are dropped
  assign conv_begin = fall_edge &
                      ((state_reg == acs_pkg::ACS_POWER_UP) | (state_reg == acs_pkg::ACS_ACQUIRE));
  assign conv_end   = (state_reg == acs_pkg::ACS_CONVERT) & (cnt_reg == '0);

  // only control bytes with a clear top field address the channel register
  assign addr_write = link.ctrl_we &
                      (link.ctrl_byte[acs_pkg::CTRL_W-1:acs_pkg::CHAN_W] == acs_pkg::CTRL_ADDR_TAG);

  // channel writes are taken any time; a running conversion already holds its count and sample
  always_comb begin
    chan_next = chan_reg;
    if (addr_write) begin
      chan_next = link.ctrl_byte[acs_pkg::CHAN_W-1:0];
    end
  end

  // channel register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_reg <= acs_pkg::CHAN_RESET;
    end else begin
      chan_reg <= chan_next;
    end
  end

  // sample freezes at the start edge; result moves only as busy falls, so a read never tears
  always_comb begin
    sample_next = sample_reg;
    result_next = result_reg;
    if (conv_begin) begin
      sample_next = is_temp_chan(chan_reg) ? temp_code : ext_code;
    end
    if (conv_end) begin
      result_next = sample_reg;
    end
  end

  // sample and result registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sample_reg <= '0;
      result_reg <= '0;
    end else begin
      sample_reg <= sample_next;
      result_reg <= result_next;
    end
  end

  // conversion sequencer: busy, power-down and the tracking status
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    pd_next    = pd_reg;
    acq_next   = acq_reg;
    held_next  = held_reg;
    unique case (state_reg)
      acs_pkg::ACS_POWER_UP, acs_pkg::ACS_ACQUIRE: begin
        if (conv_begin) begin
          state_next = acs_pkg::ACS_CONVERT;
          acq_next   = 1'b0;
          held_next  = 1'b1;
          busy_next  = 1'b1;
          // temperature conversions run three times longer
          cnt_next   = conv_load(chan_reg);
        end
      end
      acs_pkg::ACS_CONVERT: begin
        // further start edges are not looked at here
        if (conv_end) begin
          busy_next = 1'b0;
          held_next = 1'b0;
          acq_next  = 1'b1;
          // mode picked from the start level as busy falls
          if (!link.conversion_start_n) begin
            state_next = acs_pkg::ACS_POWER_DOWN;
            pd_next    = 1'b1;
          end else begin
            state_next = acs_pkg::ACS_ACQUIRE;
          end
        end else begin
          cnt_next = cnt_reg - acs_pkg::CNT_W'(1);
        end
      end
      acs_pkg::ACS_POWER_DOWN: begin
        // a low start here is ignored; only the rising edge wakes the converter
        if (rise_edge) begin
          state_next = acs_pkg::ACS_ACQUIRE;
          pd_next    = 1'b0;
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= acs_pkg::ACS_POWER_UP;
      cnt_reg   <= '0;
      busy_reg  <= 1'b0;
      pd_reg    <= 1'b0;
      acq_reg   <= 1'b1;
      held_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      pd_reg    <= pd_next;
      acq_reg   <= acq_next;
      held_reg  <= held_next;
    end
  end

  // outputs straight from flops
  assign link.busy         = busy_reg;
  assign link.result       = result_reg;
  assign link.powered_down = pd_reg;
  assign acquiring         = acq_reg;
  assign sample_held       = held_reg;
  assign channel           = chan_reg;

endmodule // acs_device
`default_nettype wire

/* File: design/acs_pkg.sv */
package acs_pkg;
  // converter word and channel widths
  localparam int RES_W  = 10;
  localparam int CHAN_W = 3;
  localparam int CTRL_W = 8;
  localparam logic [CHAN_W-1:0] CHAN_TEMP     = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_RESET    = 3'h0;
  localparam logic [4:0]        CTRL_ADDR_TAG = 5'h00;
  // timing at a 100 MHz clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_EXT_US   = 9;
  localparam int CONV_TEMP_US  = 27;
  localparam int ACQ_MIN_NS    = 100;
  localparam int QUIET_MIN_NS  = 100;
  localparam int CONV_EXT_CYC  = CONV_EXT_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_TEMP_CYC = CONV_TEMP_US * 1000 / CLK_PERIOD_NS;
  localparam int ACQ_MIN_CYC   = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_MIN_CYC = (QUIET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;
  // temperature mapping: code = (deg + 103) * 4
  localparam int TEMP_OFFSET_C = 103;
  localparam int TEMP_STEPS    = 4;

  typedef enum logic [1:0] {
    ACS_POWER_UP,
    ACS_ACQUIRE,
    ACS_CONVERT,
    ACS_POWER_DOWN
  } acs_dev_state_t;

  typedef enum logic [1:0] {
    ACS_H_IDLE,
    ACS_H_WAIT,
    ACS_H_HOLD
  } acs_host_state_t;

  // ideal temperature code for a whole degree, quarter-degree steps
  function automatic logic [RES_W-1:0] temp_to_code(input logic signed [15:0] deg);
    logic signed [15:0] c;
    c = (deg + 16'(TEMP_OFFSET_C)) * 16'(TEMP_STEPS);
    return c[RES_W-1:0];
  endfunction
endpackage

/* File: design/acs_if.sv */
`timescale 1ns/1ps
`default_nettype none
// conversion start, busy, channel write and result between host and converter
interface acs_if;
  logic                          conversion_start_n;
  logic                          busy;
  logic                          ctrl_we;
  logic [acs_pkg::CTRL_W-1:0]    ctrl_byte;
  logic [acs_pkg::RES_W-1:0]     result;
  logic                          powered_down;

  modport device (
    input  conversion_start_n,
    input  ctrl_we,
    input  ctrl_byte,
    output busy,
    output result,
    output powered_down
  );
  modport host (
    output conversion_start_n,
    output ctrl_we,
    output ctrl_byte,
    input  busy,
    input  result,
    input  powered_down
  );
endinterface
`default_nettype wire

/* File: design/acs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // link to converter
  acs_if.host       link,
  // user requests
  input  wire logic                        conv_req,
  input  wire logic                        auto_power_down,
  input  wire logic                        chan_req,
  input  wire logic [acs_pkg::CHAN_W-1:0]  chan_sel,
  // user answers
  output logic                        done,
  output logic [acs_pkg::RES_W-1:0]   data,
  output logic                        ready
);

  acs_pkg::acs_host_state_t  state_reg, state_next;
  logic                      cs_n_reg, cs_n_next;
  logic                      we_reg, we_next;
  logic [acs_pkg::CTRL_W-1:0] byte_reg, byte_next;
  logic [acs_pkg::CNT_W-1:0] quiet_reg, quiet_next;
  logic                      busy_reg;
  logic                      done_reg, done_next;
  logic [acs_pkg::RES_W-1:0] data_reg, data_next;
  logic                      mode2_reg, mode2_next;
  logic                      ready_reg, ready_next;

  // sequencing
  always_comb begin
    state_next = state_reg;
    cs_n_next  = cs_n_reg;
    we_next    = 1'b0;
    byte_next  = byte_reg;
    quiet_next = (quiet_reg != '0) ? quiet_reg - acs_pkg::CNT_W'(1) : quiet_reg;
    done_next  = 1'b0;
    data_next  = data_reg;
    mode2_next = mode2_reg;
    unique case (state_reg)
      acs_pkg::ACS_H_IDLE: begin
        // channel write also restarts the quiet time before a start
        if (chan_req) begin
          we_next    = 1'b1;
          byte_next  = {acs_pkg::CTRL_ADDR_TAG, chan_sel};
          quiet_next = acs_pkg::CNT_W'(acs_pkg::QUIET_MIN_CYC);
        end else if (conv_req && quiet_reg == '0) begin
          cs_n_next  = 1'b0;
          mode2_next = auto_power_down;
          state_next = acs_pkg::ACS_H_WAIT;
        end
      end
      acs_pkg::ACS_H_WAIT: begin
        // mode 1 releases start at once; mode 2 holds it low past busy
        if (!mode2_reg) begin
          cs_n_next = 1'b1;
        end
        if (link.busy) begin
          state_next = acs_pkg::ACS_H_HOLD;
        end
      end
      acs_pkg::ACS_H_HOLD: begin
        if (busy_reg && !link.busy) begin
          cs_n_next  = 1'b1;
          done_next  = 1'b1;
          data_next  = link.result;
          quiet_next = acs_pkg::CNT_W'(acs_pkg::ACQ_MIN_CYC);
          state_next = acs_pkg::ACS_H_IDLE;
        end
      end
      default: state_next = acs_pkg::ACS_H_IDLE;
    endcase
    // ready follows the next idle and quiet state so the output leaves a flop
    ready_next = (state_next == acs_pkg::ACS_H_IDLE) && (quiet_next == '0);
  end

  // registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= acs_pkg::ACS_H_IDLE;
      cs_n_reg  <= 1'b1;
      we_reg    <= 1'b0;
      byte_reg  <= '0;
      quiet_reg <= '0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      data_reg  <= '0;
      mode2_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cs_n_reg  <= cs_n_next;
      we_reg    <= we_next;
      byte_reg  <= byte_next;
      quiet_reg <= quiet_next;
      busy_reg  <= link.busy;
      done_reg  <= done_next;
      data_reg  <= data_next;
      mode2_reg <= mode2_next;
      ready_reg <= ready_next;
    end
  end

  assign link.conversion_start_n = cs_n_reg;
  assign link.ctrl_we            = we_reg;
  assign link.ctrl_byte          = byte_reg;
  assign done                    = done_reg;
  assign data                    = data_reg;
  assign ready                   = ready_reg;

endmodule // acs_host
`default_nettype wire

/* File: tb/acs_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_checker_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // link signals
  input wire logic       conversion_start_n,
  input wire logic       busy,
  input wire logic       ctrl_we,
  input wire logic [7:0] ctrl_byte,
  input wire logic [9:0] result,
  input wire logic       powered_down
);
  logic [2:0]  chan_reg;
  logic [2:0]  chan_next;
  logic [2:0]  cap_reg;
  logic [2:0]  cap_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  // shadow channel, channel frozen at start, busy run length
  always_comb begin
    chan_next = (ctrl_we && ctrl_byte[7:3] == 5'h00) ? ctrl_byte[2:0] : chan_reg;
    cap_next  = busy ? cap_reg : chan_reg; // a write mid-conversion must not change the count
    cnt_next  = busy ? cnt_reg + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_reg <= 3'h0;
      cap_reg  <= 3'h0;
      cnt_reg  <= 12'h000;
    end else begin
      chan_reg <= chan_next;
      cap_reg  <= cap_next;
      cnt_reg  <= cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_start_raises_busy: assert property ($fell(conversion_start_n) && !busy && !powered_down |-> ##[1:2] busy)
    else $error("busy did not follow start");
  a_busy_exact_length: assert property ($fell(busy) |-> cnt_reg == ((cap_reg == 3'h0) ? 12'h0a8c : 12'h0384))
    else $error("busy length wrong");
  a_result_on_end: assert property ($changed(result) |-> $fell(busy))
    else $error("result changed outside conversion end");
  a_mode_select: assert property ($fell(busy) |-> powered_down == !$past(conversion_start_n))
    else $error("mode not taken from start level");
  a_wake_on_rise: assert property (powered_down && $rose(conversion_start_n) |-> ##[1:2] !powered_down)
    else $error("no power-up on start rise");
  a_stay_down: assert property (powered_down && !conversion_start_n |=> powered_down && !busy)
    else $error("left power-down early");
  a_acq_spacing: assert property ($fell(busy) |-> ##1 (!$fell(conversion_start_n)) [*8])
    else $error("start too soon after end");
  a_quiet_write: assert property (ctrl_we |-> ##1 (!$fell(conversion_start_n)) [*8])
    else $error("start too soon after write");
  c_mode_one: cover property ($fell(busy) && conversion_start_n);
  c_mode_two: cover property ($fell(busy) && !conversion_start_n);
  c_write: cover property (ctrl_we);
endmodule // acs_checker_sva
`default_nettype wire

/* File: tb/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        conv_req = 1'b0;
  logic        auto_power_down = 1'b0;
  logic        chan_req = 1'b0;
  logic [2:0]  chan_sel = 3'h0;
  logic [9:0]  ext_code = 10'h000;
  logic [9:0]  temp_code = 10'h000;
  logic [9:0]  data;
  logic [2:0]  channel;
  logic        done, ready, acquiring, sample_held;
  logic [15:0] seed = 16'h67e8;
  int          bad_count = 0, n_tests = 0, cyc = 0, n, i;
  int          degs [6] = '{-55, -25, 0, 25, 55, 125};
  logic [9:0]  codes [6] = '{10'h0c0, 10'h138, 10'h19c, 10'h200, 10'h278, 10'h390};
  acs_if link ();
  acs_device acs_device_inst (.clk(clk), .reset(reset), .link(link), .ext_code(ext_code),
    .temp_code(temp_code), .acquiring(acquiring), .sample_held(sample_held), .channel(channel));
  acs_host acs_host_inst (.clk(clk), .reset(reset), .link(link), .conv_req(conv_req),
    .auto_power_down(auto_power_down), .chan_req(chan_req), .chan_sel(chan_sel), .done(done), .data(data), .ready(ready));
  acs_checker_sva acs_checker_sva_inst (.clk(clk), .reset(reset), .conversion_start_n(link.conversion_start_n),
    .busy(link.busy), .ctrl_we(link.ctrl_we), .ctrl_byte(link.ctrl_byte), .result(link.result),
    .powered_down(link.powered_down));
  always #5 clk = ~clk;
  // xorshift keeps runs repeatable
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  function automatic logic [15:0] deg_code(input int d);
    return 16'((d + 103) * 4);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // inputs move 1 ns after the edge so sampling never races
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one conversion; the unselected source carries the inverse so a wrong pick shows
  task automatic conv(input logic pd, input logic [2:0] ch, input logic [9:0] code);
    int w;
    chan_req = 1'b1;
    chan_sel = ch;
    tick(1);
    chan_req = 1'b0;
    for (w = 0; w < 20 && channel !== ch; w++) tick(1);
    check("channel", 16'(channel), 16'(ch));
    ext_code = (ch == 3'h0) ? ~code : code;
    temp_code = (ch == 3'h0) ? code : ~code;
    auto_power_down = pd;
    conv_req = 1'b1;
    for (w = 0; w < 200 && link.busy !== 1'b1; w++) tick(1);
    conv_req = 1'b0;
    check("sample_held", 16'(sample_held), 16'h0001);
    check("acquiring", 16'(acquiring), 16'h0000);
    for (n = 0; n < 3000 && link.busy === 1'b1; n++) tick(1);
    check("busy_len", 16'(n), (ch == 3'h0) ? 16'h0a8c : 16'h0384);
    check("powered_down", 16'(link.powered_down), 16'(pd));
    check("acquiring", 16'(acquiring), 16'h0001);
    check("sample_held", 16'(sample_held), 16'h0000);
    for (w = 0; w < 20 && done !== 1'b1; w++) tick(1);
    check("data", 16'(data), 16'(code));
    check("ready", 16'(ready), 16'h0000);
    ext_code = 10'(rnd());
    temp_code = 10'(rnd());
    tick(5);
    check("result", 16'(link.result), 16'(code));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    tick(12);
    reset = 1'b0;
    check("channel", 16'(channel), 16'h0000);
    check("busy", 16'(link.busy), 16'h0000);
    check("ready", 16'(ready), 16'h0001);
    for (i = 0; i < 6; i++) begin
      check("temp_map", deg_code(degs[i]), 16'(codes[i]));
      conv(i[0], 3'h0, codes[i]);
    end
    conv(1'b0, 3'h1, 10'h3ff);
    conv(1'b1, 3'h4, 10'h000);
    for (i = 0; i < 6; i++) conv(rnd() % 2 == 1, 3'(rnd() % 7 + 1), 10'(rnd() % 1024));
    final_report();
  end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
